// File: core/ups_port.sv
// user protocol serial port: registers, buffers, send and receive control
//
// Function
// R1: every sent character ends with exactly one stop bit
// R2: configuration byte selects baud rate, parity and data bits
// R3: send a counted buffer of 1 to 255 characters in order
// R4: after the last character, pulse transmit complete event 9 or 26
// R5: transmit idle flag shows running or completed sending
// R6: a count of zero sends a break for 16 bit times
// R7: a break ends like a message, with event and idle flag
// R8: receive buffer holds 1 to 255 characters, entry 0 the count
// R9: after the final stored character, pulse event 23 or 24
// R10: receive status is zero while receiving, non-zero otherwise
// R11: overrun or parity error ends reception by itself
// R12: software sets start and end condition before receiving
// R13: status bit 7 on disable command; bits 4 and 3 read zero
// R14: status bit 6 on bad parameters or missing condition
// R15: status bit 5 when the end character arrives
// R16: status bit 2 when the timer expires
// R17: run flag reads 0 in terminal position, 1 in run
// R18: status bit 1 when the maximum count is reached
// R19: status bit 0 on a parity error
// R20: protocol select value 01 enables user protocol mode
// R21: stop state leaves user protocol mode
// R22: frame is start bit, data lsb first, parity, stop bit
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module ups_port
  import ups_pkg::*;
#(
  parameter int PORT_SEL = 0
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ups_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // controller state
  input wire logic mode_switch_pin,
  input wire logic cpu_stop,
  output logic user_mode_active,
  // serial line
  input wire logic rxd,
  output logic txd,
  // events
  output logic tx_event,
  output logic [7:0] tx_event_num,
  output logic rx_event,
  output logic [7:0] rx_event_num
);
  import ups_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_COUNT, TX_CHAR, TX_BUSY} ups_txs_t;
  typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_TAKE, RX_FIN} ups_rxs_t;

  // ****************
  // configuration
  // ****************
  ups_cfg_t cfg_reg, cfg_next;
  logic [7:0] rxctl_reg, rxctl_next;
  logic [7:0] startch_reg, startch_next;
  logic [7:0] endch_reg, endch_next;
  logic [7:0] max_reg, max_next;
  logic [7:0] tmo_reg, tmo_next;
  logic sw1_reg, sw2_reg;
  logic user_mode;
  logic wr_hit_rxctl;

  // the switch is a pin, so it is synchronised before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sw1_reg <= 1'b0;
      sw2_reg <= 1'b0;
    end else begin
      sw1_reg <= mode_switch_pin;
      sw2_reg <= sw1_reg;
    end
  end

  always_comb begin
    user_mode = (cfg_reg.proto == PROTO_USER) && !cpu_stop; // R20 R21
    wr_hit_rxctl = reg_wr && (reg_addr == A_RXCTL);
    cfg_next = cfg_reg;
    rxctl_next = rxctl_reg;
    startch_next = startch_reg;
    endch_next = endch_reg;
    max_next = max_reg;
    tmo_next = tmo_reg;
    if (reg_wr) begin
      case (reg_addr)
        A_CFG: cfg_next = reg_wdata; // R2
        A_RXCTL: rxctl_next = reg_wdata;
        A_STARTCH: startch_next = reg_wdata;
        A_ENDCH: endch_next = reg_wdata;
        A_MAXCNT: max_next = reg_wdata;
        A_TMO: tmo_next = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_reg <= CFG_RST;
      rxctl_reg <= 8'h00;
      startch_reg <= 8'h00;
      endch_reg <= 8'h00;
      max_reg <= 8'h00;
      tmo_reg <= 8'h00;
    end else begin
      cfg_reg <= cfg_next;
      rxctl_reg <= rxctl_next;
      startch_reg <= startch_next;
      endch_reg <= endch_next;
      max_reg <= max_next;
      tmo_reg <= tmo_next;
    end
  end

  // ****************
  // buffers
  // ****************
  logic [7:0] tx_mem [256];
  logic [7:0] rx_mem [256];
  logic rx_we;
  logic [7:0] rx_waddr;
  logic [7:0] rx_wdata;

  always_ff @(posedge core_clk) begin
    if (reg_wr && reg_addr[9:8] == PAGE_TXBUF) begin
      tx_mem[reg_addr[7:0]] <= reg_wdata; // R3
    end
    if (rx_we) begin
      rx_mem[rx_waddr] <= rx_wdata; // R8
    end
  end

  // ****************
  // send control
  // ****************
  ups_txs_t txs_reg, txs_next;
  logic [7:0] tx_idx_reg, tx_idx_next;
  logic [7:0] tx_cnt_reg, tx_cnt_next;
  logic tx_brk_reg, tx_brk_next;
  logic tx_ev_reg, tx_ev_next;
  logic tx_start;
  logic tx_busy;
  logic [7:0] tx_char;

  always_comb begin
    txs_next = txs_reg;
    tx_idx_next = tx_idx_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_brk_next = tx_brk_reg;
    tx_ev_next = 1'b0;
    tx_start = 1'b0;
    tx_char = tx_mem[tx_idx_reg];
    case (txs_reg)
      TX_IDLE: begin
        if (reg_wr && reg_addr == A_CMD && reg_wdata[CMD_SEND] &&
            user_mode) begin
          txs_next = TX_COUNT;
          tx_idx_next = 8'h00;
        end
      end
      TX_COUNT: begin
        tx_cnt_next = tx_char;
        tx_brk_next = (tx_char == 8'h00); // R6
        tx_idx_next = 8'h01;
        txs_next = tx_brk_next ? TX_BUSY : TX_CHAR;
        tx_start = tx_brk_next && !tx_busy; // R6
        if (tx_busy) begin
          txs_next = TX_COUNT;
        end
      end
      TX_CHAR: begin
        if (!tx_busy) begin
          tx_start = 1'b1; // R3
          txs_next = TX_BUSY;
        end
      end
      TX_BUSY: begin
        if (!tx_busy) begin
          if (tx_brk_reg || tx_idx_reg == tx_cnt_reg) begin
            tx_ev_next = 1'b1; // R4 R7
            txs_next = TX_IDLE;
          end else begin
            tx_idx_next = tx_idx_reg + 8'h01; // R3
            txs_next = TX_CHAR;
          end
        end
      end
      default: txs_next = TX_IDLE;
    endcase
    // leaving user mode abandons the buffer; the current frame finishes
    if (!user_mode) begin
      txs_next = TX_IDLE; // R21
      tx_start = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      txs_reg <= TX_IDLE;
      tx_idx_reg <= 8'h00;
      tx_cnt_reg <= 8'h00;
      tx_brk_reg <= 1'b0;
      tx_ev_reg <= 1'b0;
    end else begin
      txs_reg <= txs_next;
      tx_idx_reg <= tx_idx_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_brk_reg <= tx_brk_next;
      tx_ev_reg <= tx_ev_next;
    end
  end

  ups_tx u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .start(tx_start),
    .brk(tx_brk_next),
    .data(tx_char),
    .cfg(cfg_reg),
    .line(txd),
    .busy(tx_busy)
  );

  // ****************
  // receive control
  // ****************
  ups_rxs_t rxs_reg, rxs_next;
  logic [7:0] rx_idx_reg, rx_idx_next;
  logic [7:0] rxstat_reg, rxstat_next;
  logic [7:0] tmr_reg, tmr_next;
  logic [15:0] tick_reg, tick_next;
  logic rx_ev_reg, rx_ev_next;
  logic rc_valid;
  logic [7:0] rc_data;
  logic rc_perr;
  logic rc_ov;
  logic rc_take;
  logic [7:0] term;

  ups_rx u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .rxd(rxd),
    .cfg(cfg_reg),
    .take(rc_take),
    .valid(rc_valid),
    .data(rc_data),
    .par_err(rc_perr),
    .overrun(rc_ov)
  );

  always_comb begin
    rxs_next = rxs_reg;
    rx_idx_next = rx_idx_reg;
    rxstat_next = rxstat_reg;
    rx_ev_next = 1'b0;
    rx_we = 1'b0;
    rx_waddr = rx_idx_reg + 8'h01;
    rx_wdata = rc_data;
    rc_take = (rxs_reg != RX_FIN);
    term = 8'h00;
    // bit period ticks drive the receive timer
    tick_next = tick_reg + 16'h1;
    tmr_next = tmr_reg;
    if (tick_reg >= ups_baud_div(cfg_reg.baud) - 16'h1) begin
      tick_next = 16'h0;
      tmr_next = (tmr_reg == 8'hFF) ? tmr_reg : tmr_reg + 8'h01;
    end
    case (rxs_reg)
      RX_OFF: ;
      RX_HUNT: begin
        if (rc_valid && (rc_perr || rc_ov)) begin
          term[RS_PARITY] = 1'b1; // R11 R19
        end else if (rc_valid && rc_data == startch_reg) begin
          rx_we = 1'b1; // R8
          rx_idx_next = 8'h01;
          tmr_next = 8'h00;
          rxs_next = RX_TAKE;
          if (rxctl_reg[RC_EC] && rc_data == endch_reg) begin
            term[RS_END] = 1'b1; // R15
          end else if (max_reg == 8'h01) begin
            term[RS_MAX] = 1'b1; // R18
          end
        end
      end
      RX_TAKE: begin
        if (rc_valid && (rc_perr || rc_ov)) begin
          term[RS_PARITY] = 1'b1; // R11 R19
        end else if (rc_valid) begin
          rx_we = 1'b1; // R8
          rx_idx_next = rx_idx_reg + 8'h01;
          if (!rxctl_reg[RC_CM]) begin
            tmr_next = 8'h00;
          end
          if (rxctl_reg[RC_EC] && rc_data == endch_reg) begin
            term[RS_END] = 1'b1; // R15
          end else if (rx_idx_next == max_reg) begin
            term[RS_MAX] = 1'b1; // R18
          end
        end else if (rxctl_reg[RC_TMR] && tmr_reg >= tmo_reg) begin
          term[RS_TIMER] = 1'b1; // R16
        end
      end
      RX_FIN: begin
        // count lands in entry 0 once the last character is stored
        rx_we = 1'b1; // R8
        rx_waddr = 8'h00;
        rx_wdata = rx_idx_reg;
        rx_ev_next = 1'b1; // R9
        rxs_next = RX_OFF;
      end
      default: rxs_next = RX_OFF;
    endcase
    if (rxs_reg == RX_HUNT || rxs_reg == RX_TAKE) begin
      if (wr_hit_rxctl && !reg_wdata[RC_EN]) begin
        term = 8'h00;
        term[RS_DISABLE] = 1'b1; // R13
      end else if (!user_mode) begin
        term = 8'h00;
        term[RS_DISABLE] = 1'b1; // R21
      end
      if (term != 8'h00) begin
        rxstat_next = term; // R10
        rxs_next = RX_FIN;
      end
    end else if (rxs_reg == RX_OFF && wr_hit_rxctl && reg_wdata[RC_EN]) begin
      // start character and a maximum count are both needed
      if (!reg_wdata[RC_SC] || max_reg == 8'h00 || !user_mode) begin
        rxstat_next = 8'h00;
        rxstat_next[RS_PARAM] = 1'b1; // R12 R14
      end else begin
        rxstat_next = 8'h00; // R10
        rx_idx_next = 8'h00;
        rxs_next = RX_HUNT;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxs_reg <= RX_OFF;
      rx_idx_reg <= 8'h00;
      rxstat_reg <= RXSTAT_RST;
      tmr_reg <= 8'h00;
      tick_reg <= 16'h0000;
      rx_ev_reg <= 1'b0;
    end else begin
      rxs_reg <= rxs_next;
      rx_idx_reg <= rx_idx_next;
      rxstat_reg <= rxstat_next;
      tmr_reg <= tmr_next;
      tick_reg <= tick_next;
      rx_ev_reg <= rx_ev_next;
    end
  end

  // ****************
  // read port
  // ****************
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr[9:8])
        PAGE_TXBUF: rdata_next = tx_mem[reg_addr[7:0]];
        PAGE_RXBUF: rdata_next = rx_mem[reg_addr[7:0]];
        default: begin
          case (reg_addr)
            A_CFG: rdata_next = cfg_reg;
            A_STAT: begin
              rdata_next[ST_TX_IDLE] = (txs_reg == TX_IDLE); // R5 R7
              rdata_next[ST_RUN] = sw2_reg; // R17
              rdata_next[ST_USER] = user_mode;
            end
            A_RXCTL: rdata_next = rxctl_reg;
            A_RXSTAT: rdata_next = rxstat_reg & 8'hE7; // R10 R13
            A_STARTCH: rdata_next = startch_reg;
            A_ENDCH: rdata_next = endch_reg;
            A_MAXCNT: rdata_next = max_reg;
            A_TMO: rdata_next = tmo_reg;
            default: rdata_next = 8'h00;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************
  // outputs
  // ****************
  assign reg_rdata = rdata_reg;
  assign user_mode_active = user_mode;
  assign tx_event = tx_ev_reg;
  assign rx_event = rx_ev_reg;
  assign tx_event_num = (PORT_SEL == 0) ? EV_TX_P0 : EV_TX_P1; // R4
  assign rx_event_num = (PORT_SEL == 0) ? EV_RX_P0 : EV_RX_P1; // R9

endmodule : ups_port

// File: core/ups_rx.sv
// character deserializer with parity and overrun detection
`timescale 1ns/1ps
module ups_rx
  import ups_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // line and setup
  input wire logic rxd,
  input ups_pkg::ups_cfg_t cfg,
  // character out
  input wire logic take,
  output logic valid,
  output logic [7:0] data,
  output logic par_err,
  output logic overrun
);
  import ups_pkg::*;

  typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} ups_rxs_t;

  // ****************
  // sampler
  // ****************
  logic s1_reg, s2_reg;
  ups_rxs_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [8:0] sh_reg, sh_next;
  logic [3:0] left_reg, left_next;
  logic val_reg, val_next;
  logic [7:0] dat_reg, dat_next;
  logic perr_reg, perr_next;
  logic ov_reg, ov_next;
  logic [15:0] div;
  logic [8:0] al;

  always_comb begin
    div = ups_baud_div(cfg.baud);
    al = sh_reg >> (4'h9 - ups_nbits(cfg));
    st_next = st_reg;
    cnt_next = (cnt_reg == 16'h0) ? 16'h0 : cnt_reg - 16'h1;
    sh_next = sh_reg;
    left_next = left_reg;
    val_next = val_reg && !take;
    dat_next = dat_reg;
    perr_next = perr_reg;
    ov_next = 1'b0;
    case (st_reg)
      R_IDLE: begin
        if (!s2_reg) begin
          st_next = R_START;
          cnt_next = {1'b0, div[15:1]};
        end
      end
      R_START: begin
        if (cnt_reg == 16'h0) begin
          st_next = s2_reg ? R_IDLE : R_BITS;
          cnt_next = div - 16'h1;
          left_next = ups_nbits(cfg);
        end
      end
      R_BITS: begin
        if (cnt_reg == 16'h0) begin
          sh_next = {s2_reg, sh_reg[8:1]}; // R22
          left_next = left_reg - 4'h1;
          cnt_next = div - 16'h1;
          if (left_reg == 4'h1) begin
            st_next = R_STOP;
          end
        end
      end
      R_STOP: begin
        if (cnt_reg == 16'h0) begin
          st_next = R_IDLE;
          // a held character not yet taken is lost
          ov_next = val_reg && !take; // R11
          val_next = 1'b1;
          dat_next = cfg.data7 ? {1'b0, al[6:0]} : al[7:0];
          perr_next = ups_par_on(cfg.parity) &&
            (al[ups_nbits(cfg) - 4'h1] != ups_parity(al[7:0], cfg)); // R11
        end
      end
      default: st_next = R_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      st_reg <= R_IDLE;
      cnt_reg <= 16'h0000;
      sh_reg <= 9'h000;
      left_reg <= 4'h0;
      val_reg <= 1'b0;
      dat_reg <= 8'h00;
      perr_reg <= 1'b0;
      ov_reg <= 1'b0;
    end else begin
      s1_reg <= rxd;
      s2_reg <= s1_reg;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      left_reg <= left_next;
      val_reg <= val_next;
      dat_reg <= dat_next;
      perr_reg <= perr_next;
      ov_reg <= ov_next;
    end
  end

  assign valid = val_reg;
  assign data = dat_reg;
  assign par_err = perr_reg;
  assign overrun = ov_reg;

endmodule : ups_rx

// File: core/ups_tx.sv
// character and break serializer
`timescale 1ns/1ps
module ups_tx
  import ups_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic brk,
  input wire logic [7:0] data,
  input ups_pkg::ups_cfg_t cfg,
  // line
  output logic line,
  output logic busy
);
  import ups_pkg::*;

  // ****************
  // frame shifter
  // ****************
  logic run_reg, run_next;
  logic line_reg, line_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0] left_reg, left_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] div;
  logic [10:0] frame;
  logic [3:0] nb;

  always_comb begin
    div = ups_baud_div(cfg.baud);
    nb = ups_nbits(cfg);
    // start low, data lsb first, parity, one stop bit
    frame = {2'h3, 9'h1FF} << ({1'b0, nb} + 5'h1); // R1 R22
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < (cfg.data7 ? 4'h7 : 4'h8)) begin
        frame[i + 1] = data[i]; // R22
      end
    end
    if (ups_par_on(cfg.parity)) begin
      frame[nb] = ups_parity(data, cfg); // R22
    end
    run_next = run_reg;
    sh_next = sh_reg;
    left_next = left_reg;
    cnt_next = cnt_reg;
    if (!run_reg) begin
      if (start) begin
        run_next = 1'b1;
        cnt_next = div - 16'h1;
        // break holds the line low for sixteen bit times
        sh_next = brk ? 16'h0000 : {5'h1F, frame}; // R6
        left_next = brk ? BREAK_BITS : nb + STOP_BITS + 5'h1; // R1 R6
      end
    end else if (cnt_reg == 16'h0) begin
      cnt_next = div - 16'h1;
      sh_next = {1'b1, sh_reg[15:1]};
      left_next = left_reg - 5'h1;
      if (left_reg == 5'h1) begin
        run_next = 1'b0;
      end
    end else begin
      cnt_next = cnt_reg - 16'h1;
    end
    line_next = run_next ? sh_next[0] : 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_reg <= 1'b0;
      line_reg <= 1'b1;
      sh_reg <= 16'hFFFF;
      left_reg <= 5'h00;
      cnt_reg <= 16'h0000;
    end else begin
      run_reg <= run_next;
      line_reg <= line_next;
      sh_reg <= sh_next;
      left_reg <= left_next;
      cnt_reg <= cnt_next;
    end
  end

  assign line = line_reg;
  assign busy = run_reg;

endmodule : ups_tx

// File: pkg/ups_pkg.sv
// shared constants, types and helpers for the user protocol serial port
package ups_pkg;

  // ****************
  // clock and timing
  // ****************
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_1200 = 1200;
  localparam logic [4:0] BREAK_BITS = 5'h10;
  localparam logic [4:0] STOP_BITS = 5'h01;

  // ****************
  // register map
  // ****************
  localparam int ADDR_W = 10;
  localparam logic [9:0] A_CFG = 10'h000;
  localparam logic [9:0] A_CMD = 10'h001;
  localparam logic [9:0] A_STAT = 10'h002;
  localparam logic [9:0] A_RXCTL = 10'h003;
  localparam logic [9:0] A_RXSTAT = 10'h004;
  localparam logic [9:0] A_STARTCH = 10'h005;
  localparam logic [9:0] A_ENDCH = 10'h006;
  localparam logic [9:0] A_MAXCNT = 10'h007;
  localparam logic [9:0] A_TMO = 10'h008;
  localparam logic [1:0] PAGE_TXBUF = 2'h1;
  localparam logic [1:0] PAGE_RXBUF = 2'h2;

  // ****************
  // fields and reset values
  // ****************
  localparam logic [1:0] PROTO_USER = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int CMD_SEND = 0;
  localparam int ST_TX_IDLE = 0;
  localparam int ST_RUN = 1;
  localparam int ST_USER = 2;
  localparam int RC_EN = 7;
  localparam int RC_SC = 6;
  localparam int RC_EC = 5;
  localparam int RC_TMR = 4;
  localparam int RC_CM = 3;
  localparam int RS_DISABLE = 7;
  localparam int RS_PARAM = 6;
  localparam int RS_END = 5;
  localparam int RS_TIMER = 2;
  localparam int RS_MAX = 1;
  localparam int RS_PARITY = 0;
  localparam logic [7:0] RXSTAT_RST = 8'h80;

  // ****************
  // event numbers
  // ****************
  localparam logic [7:0] EV_TX_P0 = 8'h09;
  localparam logic [7:0] EV_TX_P1 = 8'h1A;
  localparam logic [7:0] EV_RX_P0 = 8'h17;
  localparam logic [7:0] EV_RX_P1 = 8'h18;

  // parity [7:6], 7 data bits [5], baud [4:2], protocol select [1:0]
  typedef struct packed {
    logic [1:0] parity;
    logic data7;
    logic [2:0] baud;
    logic [1:0] proto;
  } ups_cfg_t;

  function automatic logic [15:0] ups_baud_div(input logic [2:0] sel);
    case (sel)
      3'h0: ups_baud_div = 16'(CLK_HZ / BAUD_38400);
      3'h1: ups_baud_div = 16'(CLK_HZ / BAUD_19200);
      3'h2: ups_baud_div = 16'(CLK_HZ / BAUD_9600);
      3'h3: ups_baud_div = 16'(CLK_HZ / BAUD_4800);
      3'h4: ups_baud_div = 16'(CLK_HZ / BAUD_2400);
      default: ups_baud_div = 16'(CLK_HZ / BAUD_1200);
    endcase
  endfunction : ups_baud_div

  function automatic logic ups_par_on(input logic [1:0] par);
    ups_par_on = (par == PAR_EVEN) || (par == PAR_ODD);
  endfunction : ups_par_on

  function automatic logic ups_parity(input logic [7:0] d,
                                      input ups_cfg_t c);
    logic p;
    p = ^(c.data7 ? {1'b0, d[6:0]} : d);
    ups_parity = (c.parity == PAR_ODD) ? ~p : p;
  endfunction : ups_parity

  // data plus parity bits of one frame
  function automatic logic [3:0] ups_nbits(input ups_cfg_t c);
    ups_nbits = (c.data7 ? 4'h7 : 4'h8) + {3'h0, ups_par_on(c.parity)};
  endfunction : ups_nbits

endpackage : ups_pkg

// File: test/ups_peer.sv
// serial peripheral model on rxd and txd
`timescale 1ns/1ps
module ups_peer #(
  parameter int DIV = 520
)
(
  // clock
  input wire logic core_clk,
  // line
  input wire logic txd,
  output logic rxd,
  // bench control
  input wire logic send_req,
  input wire logic [7:0] send_byte,
  input wire logic send_bad,
  // observations
  output logic [15:0] got_hist,
  output logic got_bad,
  output int got_cnt,
  output int low_len
);
  logic [10:0] bits;
  logic [8:0] sh;
  int run;
  // ****************
  // sender, even parity
  // ****************
  initial begin
    rxd = 1'b1;
    forever begin
      @(posedge core_clk);
      if (send_req === 1'b1) begin
        bits = {1'b1, ^send_byte ^ send_bad, send_byte, 1'b0};
        for (int i = 0; i < 11; i++) begin
          rxd <= bits[i];
          repeat (DIV) @(posedge core_clk);
        end
      end
    end
  end
  // ****************
  // decoder, mid-bit sampling
  // ****************
  initial begin
    got_hist = 16'h0000;
    got_bad = 1'b0;
    forever begin
      @(posedge core_clk);
      if (txd === 1'b0) begin
        repeat (DIV / 2) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
          repeat (DIV) @(posedge core_clk);
          sh[i] = txd;
        end
        repeat (DIV) @(posedge core_clk);
        // a break fails here, so it is never counted
        if (txd === 1'b1) begin
          got_cnt++;
          got_hist = {got_hist[7:0], sh[7:0]};
          if (^sh !== 1'b0) got_bad = 1'b1;
        end
        while (txd !== 1'b1) @(posedge core_clk);
      end
    end
  end
  always @(posedge core_clk) begin
    if (txd === 1'b0) run <= run + 1;
    else if (run > 0) begin
      low_len <= run;
      run <= 0;
    end
  end
endmodule : ups_peer

// File: test/ups_port_bench.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
module ups_port_bench;
  import ups_pkg::*;
  localparam int DIV = 520;
  logic core_clk, rxd, txd, tx_event, rx_event, g_bad, user_mode_active;
  logic rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cpu_stop = 1'b0;
  logic mode_switch_pin = 1'b0, s_req = 1'b0, s_bad = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, s_byte = 8'h00, reg_rdata;
  logic [7:0] tx_event_num, rx_event_num;
  logic [15:0] g_hist;
  int err_total, n_tests, g_cnt, low_len, tx_seen, rx_seen;
  ups_port #(.PORT_SEL(1)) dut (.*);
  ups_peer #(.DIV(DIV)) peer (.core_clk(core_clk), .txd(txd), .rxd(rxd),
    .send_req(s_req), .send_byte(s_byte), .send_bad(s_bad),
    .got_hist(g_hist), .got_bad(g_bad), .got_cnt(g_cnt),
    .low_len(low_len));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // one-cycle events, counted as they pass
  always @(posedge core_clk) begin
    if (tx_event === 1'b1) tx_seen <= tx_seen + 1;
    if (rx_event === 1'b1) rx_seen <= rx_seen + 1;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(16'(reg_rdata), 16'(e));
  endtask : rd
  task automatic wait_ev(input logic rx, input int n);
    for (int i = 0; i < 30000; i++) begin
      @(posedge core_clk);
      if ((rx ? rx_seen : tx_seen) >= n) return;
    end
    err_total++;
    $display("CHECK FAILED t=%0t timeout", $time);
    test_done();
  endtask : wait_ev
  task automatic snd(input logic [7:0] b, input logic bad);
    s_byte <= b;
    s_bad <= bad;
    s_req <= 1'b1;
    @(posedge core_clk);
    s_req <= 1'b0;
    repeat (11 * DIV + 8) @(posedge core_clk);
  endtask : snd
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(A_RXSTAT, RXSTAT_RST);
    rd(A_STAT, 8'h01);
    rd(A_CFG, CFG_RST);
    rd(10'h3FF, 8'h00);
    $display("reset test done");
    wr(A_CFG, 8'h41);
    rd(A_CFG, 8'h41);
    cmp(16'(user_mode_active), 16'h0001);
    wr(10'h100, 8'h02);
    wr(10'h101, 8'h5A);
    wr(10'h102, 8'hC3);
    wr(A_CMD, 8'h01);
    rd(A_STAT, 8'h04);
    wait_ev(1'b0, 1);
    cmp(g_hist, 16'h5AC3);
    cmp(g_cnt[15:0], 16'h0002);
    cmp(16'(g_bad), 16'h0000);
    cmp(16'(tx_event_num), 16'(EV_TX_P1));
    rd(A_STAT, 8'h05);
    wr(10'h100, 8'h00);
    wr(A_CMD, 8'h01);
    wait_ev(1'b0, 2);
    cmp(low_len[15:0], 16'(16 * DIV));
    rd(A_STAT, 8'h05);
    $display("send test done");
    wr(A_STARTCH, 8'h53);
    wr(A_ENDCH, 8'h45);
    wr(A_MAXCNT, 8'h0A);
    wr(A_RXCTL, 8'hE0);
    rd(A_RXSTAT, 8'h00);
    snd(8'h53, 1'b0);
    snd(8'h78, 1'b0);
    rd(A_RXSTAT, 8'h00);
    snd(8'h45, 1'b0);
    wait_ev(1'b1, 1);
    rd(A_RXSTAT, 8'h20);
    rd(10'h200, 8'h03);
    rd(10'h202, 8'h78);
    cmp(16'(rx_event_num), 16'(EV_RX_P1));
    wr(A_MAXCNT, 8'h02);
    wr(A_RXCTL, 8'hC0);
    snd(8'h53, 1'b0);
    snd(8'h11, 1'b0);
    wait_ev(1'b1, 2);
    rd(A_RXSTAT, 8'h02);
    rd(10'h200, 8'h02);
    wr(A_RXCTL, 8'hC0);
    snd(8'h53, 1'b1);
    wait_ev(1'b1, 3);
    rd(A_RXSTAT, 8'h01);
    wr(A_RXCTL, 8'hC0);
    wr(A_RXCTL, 8'h00);
    wait_ev(1'b1, 4);
    rd(A_RXSTAT, 8'h80);
    wr(A_RXCTL, 8'h80);
    rd(A_RXSTAT, 8'h40);
    $display("receive test done");
    mode_switch_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(A_STAT, 8'h07);
    cpu_stop <= 1'b1;
    @(posedge core_clk);
    cmp(16'(user_mode_active), 16'h0000);
    rd(A_STAT, 8'h03);
    mode_switch_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(A_STAT, 8'h01);
    $display("mode test done");
    test_done();
  end
endmodule : ups_port_bench

// File: test/ups_port_chk.sv
// assertions on the serial port pins
`timescale 1ns/1ps
module ups_chk
  import ups_pkg::*;
#(
  parameter int PORT_SEL = 0
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // state and line
  input wire logic cpu_stop,
  input wire logic user_mode_active,
  input wire logic txd,
  // events
  input wire logic tx_event,
  input wire logic [7:0] tx_event_num,
  input wire logic rx_event,
  input wire logic [7:0] rx_event_num
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_tx_num: assert property (
    tx_event_num == (PORT_SEL ? EV_TX_P1 : EV_TX_P0)) else $error("tx num");
  chk_rx_num: assert property (
    rx_event_num == (PORT_SEL ? EV_RX_P1 : EV_RX_P0)) else $error("rx num");
  chk_tx_pulse: assert property (
    tx_event |=> !tx_event) else $error("tx pulse");
  chk_rx_pulse: assert property (
    rx_event |=> !rx_event) else $error("rx pulse");
  chk_stop_off: assert property (
    cpu_stop |-> !user_mode_active) else $error("stop mode");
  chk_start_bit: assert property (
    $fell(txd) |-> !txd [*8]) else $error("start bit");
  chk_stop_bit: assert property (
    $rose(txd) |-> txd [*8]) else $error("stop bit");
  chk_ev_line: assert property (
    tx_event |-> txd && $past(txd)) else $error("early event");
  chk_zero_bits: assert property (
    reg_rd && reg_addr == A_RXSTAT |=> reg_rdata[4:3] == 2'h0)
    else $error("bits 4 3");
  cov_tx: cover property (tx_event);
  cov_rx: cover property (rx_event);
  cov_stop: cover property (cpu_stop && $fell(user_mode_active));
endmodule : ups_chk
bind ups_port ups_chk #(.PORT_SEL(PORT_SEL)) u_chk (.*);
